//--- stc_pkg.sv
// Package with register map, field layout, reset values and types of the SYSREF timing calibration.
// What this block does
// - Configuration bits 3:2 reset to 1 and pick 4, 16, 64 or 256 averages for codes 0 to 3.
// - Configuration bits 1:0 reset to 1 and pick 4, 16, 64 or 256 cycles per accumulation.
// - A longer accumulation lowers the variance of the result at the price of a longer run.
// - A run ends within 384 * 19 * 4^(average code + accumulation code + 2) cycles.
// - Status bit 17 reads 1 only while calibration is enabled and the run has finished.
// - Status bits 16:0 carry the computed delay word, meaningful only once bit 17 is 1.
// - In the delay word bit 16 is the clock invert, 15:8 the coarse and 7:0 the fine delay.
// - The status register cannot be written and holds no meaning before the first result.
// - The manual delay register resets to zero with coarse delay in 15:8 and fine in 7:0.
// - A 0-to-1 change of the enable bit launches a calibration run.
// - While enabled the manual register is ignored; while disabled it alone drives the delay.
// - Bit 16 of the manual register inverts the sampling clock when set.
package stc_pkg;

  // Register addresses as they stand on the configuration port.
  localparam logic [11:0] STC_ADDR_ENABLE = 12'h2b0;
  localparam logic [11:0] STC_ADDR_CONFIG = 12'h2b1;
  localparam logic [11:0] STC_ADDR_STATUS = 12'h2b2;
  localparam logic [11:0] STC_ADDR_MANUAL = 12'h2b5;

  // Field positions and reset values.
  localparam int STC_ENABLE_BIT = 0;
  localparam int STC_AVG_LSB = 2;
  localparam int STC_ACC_LSB = 0;
  localparam int STC_DONE_BIT = 17;
  localparam logic [3:0] STC_CONFIG_RESET = 4'h5;
  localparam logic [16:0] STC_MANUAL_RESET = 17'h00000;

  // Base count of one accumulation and the run-time bound factor 384 * 19.
  localparam logic [8:0] STC_ACC_BASE = 9'h004;
  localparam logic [31:0] STC_BOUND_BASE = 32'h00001c80;

  // Delay word applied to the sampling clock path.
  typedef struct packed {
    logic clk_invert;
    logic [7:0] coarse;
    logic [7:0] fine;
  } stc_delay_s;

  // Configuration fields.
  typedef struct packed {
    logic [1:0] average_count_sel;
    logic [1:0] accumulation_length_sel;
  } stc_cfg_s;

  // Calibration engine states.
  typedef enum logic [1:0] {
    STC_IDLE = 2'b00,
    STC_WAIT_EDGE = 2'b01,
    STC_ACCUM = 2'b10,
    STC_DONE = 2'b11
  } stc_state_e;

endpackage

//--- stc_sysref_cal.sv
// SYSREF timing calibration engine with its configuration, status and manual delay registers.
`timescale 1ns/100ps
module stc_sysref_cal import stc_pkg::*; (
  // Clock and reset.
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  // Register port from the configuration interface, same clock.
  input wire logic [11:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [23:0] REG_WDATA_I,
  output logic [23:0] REG_RDATA_O,
  // Pins from the clock path.
  input wire logic SYSREF_I,
  input wire logic [16:0] PHASE_I,
  // Delay word to the aperture delay line.
  output stc_delay_s DELAY_WORD_O
);

  logic [1:0] sysref_sync_ff;
  logic sysref_prev_ff;
  logic [16:0] phase_meta_ff;
  logic [16:0] phase_ff;
  logic calibration_enable_ff, nxt_calibration_enable;
  logic enable_prev_ff;
  stc_cfg_s cfg_ff, nxt_cfg;
  stc_delay_s manual_ff, nxt_manual;
  stc_delay_s computed_delay_word_ff, nxt_computed_delay_word;
  stc_delay_s delay_out_ff, nxt_delay_out;
  logic [23:0] rdata_ff, nxt_rdata;
  stc_state_e state_ff, nxt_state;
  logic [8:0] acc_cnt_ff, nxt_acc_cnt;
  logic [8:0] avg_cnt_ff, nxt_avg_cnt;
  logic [32:0] sum_ff, nxt_sum;
  logic [31:0] run_cyc_ff, nxt_run_cyc;
  logic [8:0] acc_len;
  logic [8:0] avg_num;
  logic [4:0] shift;
  logic [32:0] sum_in;
  logic [16:0] avg_value;
  logic sysref_rise;
  logic launch;
  logic calibration_complete;

  // Two flops on each pin, plus a third on SYSREF for its edge; logic never looks at the first stage.
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sysref_sync_ff <= 2'h0;
      sysref_prev_ff <= 1'h0;
      phase_meta_ff <= 17'h00000;
      phase_ff <= 17'h00000;
    end else begin
      sysref_sync_ff <= {sysref_sync_ff[0], SYSREF_I};
      sysref_prev_ff <= sysref_sync_ff[1];
      phase_meta_ff <= PHASE_I;
      phase_ff <= phase_meta_ff;
    end
  end

  // Decoded sizes; the phase bus is assumed steady between SYSREF edges, so plain syncing holds.
  always_comb begin
    acc_len = STC_ACC_BASE << {cfg_ff.accumulation_length_sel, 1'b0};
    avg_num = STC_ACC_BASE << {cfg_ff.average_count_sel, 1'b0};
    // Five bits: the widest setting shifts by 16, which would wrap a four-bit count to zero.
    shift = 5'({cfg_ff.average_count_sel, 1'b0}) + 5'({cfg_ff.accumulation_length_sel, 1'b0})
      + 5'h04;
    sysref_rise = sysref_sync_ff[1] && !sysref_prev_ff;
    launch = calibration_enable_ff && !enable_prev_ff;
    sum_in = sum_ff + {16'h0000, phase_ff};
    avg_value = 17'(sum_in >> shift);
    calibration_complete = calibration_enable_ff && (state_ff == STC_DONE);
  end

  // Register writes; the status address takes no write at all.
  always_comb begin
    nxt_calibration_enable = calibration_enable_ff;
    nxt_cfg = cfg_ff;
    nxt_manual = manual_ff;
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        STC_ADDR_ENABLE: nxt_calibration_enable = REG_WDATA_I[STC_ENABLE_BIT];
        STC_ADDR_CONFIG: nxt_cfg = REG_WDATA_I[3:0];
        STC_ADDR_MANUAL: nxt_manual = REG_WDATA_I[16:0];
        default: nxt_calibration_enable = calibration_enable_ff;
      endcase
    end
  end

  // Read mux, answered one cycle after the address; reserved bits read zero.
  always_comb begin
    case (REG_ADDR_I)
      STC_ADDR_ENABLE: nxt_rdata = {23'h000000, calibration_enable_ff};
      STC_ADDR_CONFIG: nxt_rdata = {20'h00000, cfg_ff};
      STC_ADDR_STATUS: nxt_rdata = {6'h00, calibration_complete, computed_delay_word_ff};
      STC_ADDR_MANUAL: nxt_rdata = {7'h00, manual_ff};
      default: nxt_rdata = 24'h000000;
    endcase
  end

  // Engine: wait for a SYSREF edge, accumulate, repeat per average, then load the word.
  always_comb begin
    nxt_state = state_ff;
    nxt_acc_cnt = acc_cnt_ff;
    nxt_avg_cnt = avg_cnt_ff;
    nxt_sum = sum_ff;
    nxt_computed_delay_word = computed_delay_word_ff;
    nxt_run_cyc = (state_ff == STC_WAIT_EDGE || state_ff == STC_ACCUM) ? run_cyc_ff + 32'h1
      : 32'h0;
    case (state_ff)
      STC_IDLE: begin
        if (launch) begin
          nxt_state = STC_WAIT_EDGE;
          nxt_sum = 33'h0;
          nxt_avg_cnt = 9'h000;
        end
      end
      STC_WAIT_EDGE: begin
        nxt_acc_cnt = 9'h000;
        if (sysref_rise) begin
          nxt_state = STC_ACCUM;
        end
      end
      STC_ACCUM: begin
        nxt_sum = sum_in;
        nxt_acc_cnt = acc_cnt_ff + 9'h001;
        if (acc_cnt_ff == acc_len - 9'h001) begin
          nxt_avg_cnt = avg_cnt_ff + 9'h001;
          nxt_state = STC_WAIT_EDGE;
          if (avg_cnt_ff == avg_num - 9'h001) begin
            nxt_computed_delay_word = avg_value;
            nxt_state = STC_DONE;
          end
        end
      end
      STC_DONE: nxt_state = STC_DONE;
      default: nxt_state = STC_IDLE;
    endcase
    // Dropping the enable aborts a run and clears completion at once.
    if (!calibration_enable_ff) begin
      nxt_state = STC_IDLE;
    end
  end

  // Manual word alone drives the line while disabled; the calibrated word otherwise.
  always_comb begin
    nxt_delay_out = calibration_enable_ff ? computed_delay_word_ff : manual_ff;
  end

  // State registers.
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      calibration_enable_ff <= 1'h0;
      enable_prev_ff <= 1'h0;
      cfg_ff <= STC_CONFIG_RESET;
      manual_ff <= STC_MANUAL_RESET;
      computed_delay_word_ff <= 17'h00000;
      delay_out_ff <= 17'h00000;
      rdata_ff <= 24'h000000;
      state_ff <= STC_IDLE;
      acc_cnt_ff <= 9'h000;
      avg_cnt_ff <= 9'h000;
      sum_ff <= 33'h0;
      run_cyc_ff <= 32'h0;
    end else begin
      calibration_enable_ff <= nxt_calibration_enable;
      enable_prev_ff <= calibration_enable_ff;
      cfg_ff <= nxt_cfg;
      manual_ff <= nxt_manual;
      computed_delay_word_ff <= nxt_computed_delay_word;
      delay_out_ff <= nxt_delay_out;
      rdata_ff <= nxt_rdata;
      state_ff <= nxt_state;
      acc_cnt_ff <= nxt_acc_cnt;
      avg_cnt_ff <= nxt_avg_cnt;
      sum_ff <= nxt_sum;
      run_cyc_ff <= nxt_run_cyc;
    end
  end

  assign REG_RDATA_O = rdata_ff;
  assign DELAY_WORD_O = delay_out_ff;

  // Checks tied to the engine and the register port.
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  enable_launch_a: assert property (
    (calibration_enable_ff && !enable_prev_ff && state_ff == STC_IDLE)
      |=> state_ff == STC_WAIT_EDGE)
    else $error("Rising enable did not launch a run.");
  done_status_a: assert property (
    (!REG_WR_I && REG_ADDR_I == STC_ADDR_STATUS)
      |=> REG_RDATA_O[STC_DONE_BIT] == $past(calibration_enable_ff && state_ff == STC_DONE))
    else $error("Completion bit disagrees with enable and engine state.");
  manual_drive_a: assert property (
    (!calibration_enable_ff ##1 !calibration_enable_ff)
      |=> DELAY_WORD_O == $past(manual_ff))
    else $error("Manual word does not drive the delay while disabled.");
  calc_drive_a: assert property (
    calibration_enable_ff |=> DELAY_WORD_O == $past(computed_delay_word_ff))
    else $error("Calibrated word does not drive the delay while enabled.");
  run_bound_a: assert property (
    run_cyc_ff <= (STC_BOUND_BASE << shift))
    else $error("Calibration run exceeds its time bound.");
  acc_length_a: assert property (
    $fell(state_ff == STC_ACCUM) && calibration_enable_ff && $past(calibration_enable_ff)
      |-> $past(acc_cnt_ff) == $past(acc_len) - 9'h001)
    else $error("Accumulation length differs from the selected count.");
  avg_count_a: assert property (
    $rose(state_ff == STC_DONE) |-> avg_cnt_ff == $past(avg_num))
    else $error("Number of averages differs from the selected count.");
  result_load_a: assert property (
    $rose(state_ff == STC_DONE) |-> computed_delay_word_ff == $past(avg_value))
    else $error("Averaged word not loaded at completion.");
  status_ro_a: assert property (
    (REG_WR_I && REG_ADDR_I == STC_ADDR_STATUS && state_ff != STC_ACCUM)
      |=> computed_delay_word_ff == $past(computed_delay_word_ff))
    else $error("Status word changed by a register write.");

  // Main scenarios: a launch, a finished run, an aborted run and a manual write.
  launch_c: cover property (launch && state_ff == STC_IDLE);
  run_done_c: cover property ($rose(state_ff == STC_DONE));
  abort_run_c: cover property (state_ff == STC_ACCUM ##1 state_ff == STC_IDLE);
  manual_write_c: cover property (REG_WR_I && REG_ADDR_I == STC_ADDR_MANUAL
    && !calibration_enable_ff);

endmodule // stc_sysref_cal

//--- stc_clkgen_model.sv
// Clock-generator model that supplies SYSREF pulses and a steady phase word.
`timescale 1ns/100ps
module stc_clkgen_model (
  // Clock, reset and settings from the bench.
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [15:0] period_i,
  input wire logic [16:0] phase_i,
  // Pins toward the device.
  output logic sysref_o,
  output logic [16:0] phase_o
);
  logic [15:0] cnt_ff;
  // The phase word is held steady for a whole run, so every accumulation sees one value.
  assign phase_o = phase_i;
  // Free-running SYSREF, high for the first half of each period.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= 16'h0000;
      sysref_o <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff + 16'h0001 >= period_i) ? 16'h0000 : cnt_ff + 16'h0001;
      sysref_o <= (cnt_ff < (period_i >> 1));
    end
  end
endmodule // stc_clkgen_model

//--- tb.sv
// Self-checking bench for the SYSREF timing calibration block.
`timescale 1ns/100ps
module tb;
  import stc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] addr = 12'h000;
  logic wr = 1'b0;
  logic [23:0] wdata = 24'h000000;
  logic [23:0] rdata;
  logic sysref;
  logic [16:0] phase;
  stc_delay_s dly;
  logic [15:0] period = 16'h0020;
  logic [16:0] ph_set = 17'h00000;
  logic [23:0] got;
  int mismatches = 0;
  int checks_done = 0;
  logic [3:0] cfg_tab [5] = '{4'h0, 4'h5, 4'ha, 4'h3, 4'hc};
  logic [16:0] ph_tab [5] = '{17'h12345, 17'h000ff, 17'h1ff00, 17'h07a5c, 17'h10001};
  // Device clock at 250 MHz.
  always #2 clk = ~clk;
  stc_sysref_cal i_dut (.REF_CLK_I(clk), .RSTN_I(rstn), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .SYSREF_I(sysref), .PHASE_I(phase),
    .DELAY_WORD_O(dly));
  stc_clkgen_model i_gen (.clk_i(clk), .rstn_i(rstn), .period_i(period), .phase_i(ph_set),
    .sysref_o(sysref), .phase_o(phase));
  // Compare and count; an unknown never matches.
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Write takes one edge, then an idle edge so the strobe is never re-raised in the same step.
  task automatic wr_reg(input logic [11:0] a, input logic [23:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  // Read data is registered, so it is settled just after the edge that samples the address.
  task automatic rd_reg(input logic [11:0] a);
    addr = a;
    @(posedge clk);
    #1;
    got = rdata;
  endtask
  // One calibration run with a constant phase; the average of a constant is that constant.
  task automatic run_cal(input logic [3:0] cfg, input logic [16:0] ph);
    int lim;
    int n;
    lim = 7296 << (2 * (int'(cfg[3:2]) + int'(cfg[1:0]) + 2));
    period = 16'((4 << (2 * int'(cfg[1:0]))) + 24);
    ph_set = ph;
    wr_reg(STC_ADDR_CONFIG, {20'h00000, cfg});
    rd_reg(STC_ADDR_CONFIG);
    chk(got, {20'h00000, cfg});
    wr_reg(STC_ADDR_ENABLE, 24'h000001);
    n = 0;
    got = 24'h000000;
    while (got[17] !== 1'b1 && n < lim) begin
      rd_reg(STC_ADDR_STATUS);
      n++;
    end
    chk(got, {6'h00, 1'b1, ph});
    wr_reg(STC_ADDR_ENABLE, 24'h000001);
    wr_reg(STC_ADDR_MANUAL, 24'h000abc);
    rd_reg(STC_ADDR_STATUS);
    chk(got, {6'h00, 1'b1, ph});
    chk({7'h00, dly}, {7'h00, ph});
    wr_reg(STC_ADDR_ENABLE, 24'h000000);
    rd_reg(STC_ADDR_STATUS);
    chk(got, {7'h00, ph});
    chk({7'h00, dly}, 24'h000abc);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence: reset values, manual path, refused writes, then one run at each of five config codes.
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk({7'h00, dly}, 24'h000000);
    rd_reg(STC_ADDR_CONFIG);
    chk(got, 24'h000005);
    rd_reg(STC_ADDR_MANUAL);
    chk(got, 24'h000000);
    rd_reg(STC_ADDR_STATUS);
    chk(got, 24'h000000);
    rd_reg(12'h2b3);
    chk(got, 24'h000000);
    wr_reg(STC_ADDR_MANUAL, 24'hffa53c);
    rd_reg(STC_ADDR_MANUAL);
    chk(got, 24'h01a53c);
    chk({7'h00, dly}, 24'h01a53c);
    wr_reg(STC_ADDR_STATUS, 24'hffffff);
    rd_reg(STC_ADDR_STATUS);
    chk(got, 24'h000000);
    // Launch, read the enable back, then abort long before a run could finish.
    wr_reg(STC_ADDR_ENABLE, 24'h000001);
    rd_reg(STC_ADDR_ENABLE);
    chk(got, 24'h000001);
    repeat (20) @(posedge clk);
    #1;
    wr_reg(STC_ADDR_ENABLE, 24'h000000);
    rd_reg(STC_ADDR_STATUS);
    chk(got, 24'h000000);
    chk({7'h00, dly}, 24'h01a53c);
    for (int i = 0; i < 5; i++) begin
      run_cal(cfg_tab[i], ph_tab[i]);
    end
    complete_run();
  end
  // Watchdog sized well above the longest expected run time.
  initial begin
    #160000;
    mismatches++;
    complete_run();
  end
endmodule // tb
